// *** src/ctf_pkg.sv ***
// shared constants and carrier types for the control timer fault/event logic
package ctf_pkg;
    localparam int CNT_W = 16;
    localparam logic [2:0] FCA_DISABLE     = 3'h0;
    localparam logic [2:0] FCA_STORE       = 3'h1;
    localparam logic [2:0] FCA_IF_LOWER    = 3'h2;
    localparam logic [2:0] FCA_IF_HIGHER   = 3'h3;
    localparam logic [2:0] FCA_LOCAL_LOW   = 3'h4;
    localparam logic [2:0] FCA_LOCAL_HIGH  = 3'h5;
    localparam logic [2:0] FCA_LOCAL_EXTR  = 3'h6;
    localparam logic [2:0] EV_OFF          = 3'h0;
    localparam logic [2:0] EV_RETRIGGER    = 3'h1;
    localparam logic [2:0] EV0_TALLY       = 3'h2;
    localparam logic [2:0] EV0_START       = 3'h3;
    localparam logic [2:0] EV0_INC         = 3'h4;
    localparam logic [2:0] EV0_COUNT_LEVEL = 3'h5;
    localparam logic [2:0] EV0_STAMP       = 3'h6;
    localparam logic [2:0] EV1_DIR         = 3'h2;
    localparam logic [2:0] EV1_STOP        = 3'h3;
    localparam logic [2:0] EV1_DEC         = 3'h4;
    localparam logic [2:0] EV1_PER_WIDTH   = 3'h5;
    localparam logic [2:0] EV1_WIDTH_PER   = 3'h6;
    localparam logic [2:0] EV_FAULT        = 3'h7;
    localparam logic [1:0] CYC_BEGIN       = 2'h0;
    localparam logic [1:0] CYC_END         = 2'h1;
    localparam logic [1:0] CYC_BETWEEN     = 2'h2;
    localparam logic [1:0] CYC_BOUNDARY    = 2'h3;
    localparam logic [1:0] HALT_NONE       = 2'h0;
    localparam logic [1:0] HALT_HW         = 2'h1;
    localparam logic [1:0] HALT_SW         = 2'h2;
    localparam logic [1:0] HALT_NONREC     = 2'h3;
    // control word: [11:10] channel, [9:8] halt, [7:6] cycle out, [5:3] ev1, [2:0] ev0
    typedef struct packed {
        logic [1:0] fault_store_channel_select;
        logic [1:0] halt_action;
        logic [1:0] cycle_output_select;
        logic [2:0] input1_event_action;
        logic [2:0] input0_event_action;
    } ctf_ctrl_t;
    typedef enum logic [1:0] {
        CTF_IDLE = 2'b00,
        CTF_RUN  = 2'b01,
        CTF_HALT = 2'b11
    } ctf_state_t;
endpackage : ctf_pkg

// *** src/ctf_top.sv ***
// fault capture, event input actions and counter event output of the control timer
`timescale 1ns/1ps
`default_nettype none
module ctf_top #(
    parameter int CNT_W = ctf_pkg::CNT_W
) (
    // clock and reset
    input  wire logic               SYS_CLK_I,
    input  wire logic               RESET_I,
    // configuration
    input  wire ctf_pkg::ctf_ctrl_t CTRL_I,
    input  wire logic               OVF_EVENT_EN_I,
    input  wire logic [CNT_W-1:0]   PERIOD_I,
    input  wire logic               SW_START_I,
    input  wire logic [2:0]         FAULT_ACTION_I,
    // events and faults
    input  wire logic               EVENT_INPUT_ZERO_I,
    input  wire logic               EVENT_INPUT_ONE_I,
    input  wire logic               FAULT_I,
    input  wire logic               FAULT_FLAG_CLR_I,
    // status
    output logic [CNT_W-1:0]        COUNT_O,
    output logic [4*CNT_W-1:0]      STORE_O,
    output logic                    FAULT_FLAG_O,
    output logic                    COUNTER_EVENT_O,
    output logic                    NONREC_FAULT_O,
    output logic                    HALTED_O,
    output logic [1:0]              STATE_O
);
    ctf_pkg::ctf_ctrl_t  ctrl_meta, ctrl;
    logic                ovf_en_meta, ovf_en;
    logic                ev0_q, ev1_q, fault_q;
    logic                ev0_rise, ev1_rise, fault_rise;
    ctf_pkg::ctf_state_t state;
    logic [CNT_W-1:0]    cnt;
    logic                dir_down;
    logic [CNT_W-1:0]    store [4];
    logic [CNT_W-1:0]    last_store;
    logic [CNT_W-1:0]    prev_fault_cnt;
    logic                prev_rising;
    logic                have_prev;
    logic                first_cycle;
    logic [CNT_W-1:0]    width_start;
    logic                wrap, do_step, step_down;
    logic                fault_store, fault_flag_set;
    logic                is_low, is_high;
    logic [2:0]          fa_meta, fault_action;

    // config except PERIOD_I and SW_START_I crosses into the counter domain through two stages
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ctrl_meta   <= '0;
            ctrl        <= '0;
            ovf_en_meta <= 1'b0;
            ovf_en      <= 1'b0;
            fa_meta     <= ctf_pkg::FCA_DISABLE;
            fault_action <= ctf_pkg::FCA_DISABLE;
        end else begin
            ctrl_meta   <= CTRL_I;
            ctrl        <= ctrl_meta;
            ovf_en_meta <= OVF_EVENT_EN_I;
            ovf_en      <= ovf_en_meta;
            // capture action takes the same two-stage path as the control word
            fa_meta     <= FAULT_ACTION_I;
            fault_action <= fa_meta;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ev0_q   <= 1'b0;
            ev1_q   <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            ev0_q   <= EVENT_INPUT_ZERO_I;
            ev1_q   <= EVENT_INPUT_ONE_I;
            fault_q <= FAULT_I;
        end
    end
    assign ev0_rise   = EVENT_INPUT_ZERO_I & ~ev0_q;
    assign ev1_rise   = EVENT_INPUT_ONE_I & ~ev1_q;
    assign fault_rise = FAULT_I & ~fault_q;

    // counting steps; no sleep gating here, only the run state and the event actions gate the counter
    always_comb begin
        do_step   = 1'b1;
        step_down = dir_down;
        case (ctrl.input0_event_action)
            ctf_pkg::EV0_TALLY:       do_step = ev0_rise;
            ctf_pkg::EV0_INC:         begin
                do_step   = ev0_rise;
                step_down = 1'b0;
            end
            ctf_pkg::EV0_COUNT_LEVEL: do_step = EVENT_INPUT_ZERO_I;
            default:                  do_step = 1'b1;
        endcase
        if (ctrl.input1_event_action == ctf_pkg::EV1_DEC) begin
            do_step   = ev1_rise;
            step_down = 1'b1;
        end
        if (state != ctf_pkg::CTF_RUN) begin
            do_step = 1'b0;
        end
    end
    assign wrap = do_step & (step_down ? (cnt == '0) : (cnt == PERIOD_I));

    logic halt_now;
    assign halt_now = fault_rise & (ctrl.halt_action != ctf_pkg::HALT_NONE);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            state <= ctf_pkg::CTF_IDLE;
        end else begin
            case (state)
                ctf_pkg::CTF_IDLE: begin
                    if (SW_START_I
                        || (ev0_rise && ctrl.input0_event_action == ctf_pkg::EV0_START)
                        || (ev0_rise && ctrl.input0_event_action == ctf_pkg::EV_RETRIGGER)
                        || (ev1_rise && ctrl.input1_event_action == ctf_pkg::EV_RETRIGGER)) begin
                        state <= ctf_pkg::CTF_RUN;
                    end
                end
                ctf_pkg::CTF_RUN: begin
                    if (halt_now) begin
                        state <= ctf_pkg::CTF_HALT;
                    end else if (ev1_rise && ctrl.input1_event_action == ctf_pkg::EV1_STOP) begin
                        state <= ctf_pkg::CTF_IDLE;
                    end
                end
                ctf_pkg::CTF_HALT: begin
                    if (!FAULT_I && ctrl.halt_action == ctf_pkg::HALT_HW) begin
                        state <= ctf_pkg::CTF_RUN;
                    end else if (SW_START_I) begin
                        state <= ctf_pkg::CTF_RUN;
                    end
                end
                default: state <= ctf_pkg::CTF_IDLE;
            endcase
        end
    end

    logic retrig;
    assign retrig = (ev0_rise && ctrl.input0_event_action == ctf_pkg::EV_RETRIGGER)
                 || (ev1_rise && ctrl.input1_event_action == ctf_pkg::EV_RETRIGGER);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            cnt      <= '0;
            dir_down <= 1'b0;
        end else begin
            if (ctrl.input1_event_action == ctf_pkg::EV1_DIR) begin
                dir_down <= EVENT_INPUT_ONE_I;
            end
            if (retrig) begin
                cnt <= step_down ? PERIOD_I : '0;
            end else if (do_step) begin
                if (wrap) begin
                    cnt <= step_down ? PERIOD_I : '0;
                end else begin
                    cnt <= step_down ? cnt - 1'b1 : cnt + 1'b1;
                end
            end
        end
    end

    // local extremes: a rising trend that turns falling marks a high, and vice versa
    assign is_high = have_prev & prev_rising & (cnt < prev_fault_cnt);
    assign is_low  = have_prev & ~prev_rising & (cnt > prev_fault_cnt);

    always_comb begin
        fault_store    = 1'b0;
        fault_flag_set = 1'b0;
        if (fault_rise) begin
            case (fault_action)
                ctf_pkg::FCA_STORE: begin
                    fault_store    = 1'b1;
                    fault_flag_set = 1'b1;
                end
                ctf_pkg::FCA_IF_LOWER: begin
                    fault_store    = cnt < last_store;
                    fault_flag_set = cnt < last_store;
                end
                ctf_pkg::FCA_IF_HIGHER: begin
                    fault_store    = cnt > last_store;
                    fault_flag_set = cnt > last_store;
                end
                ctf_pkg::FCA_LOCAL_LOW: begin
                    fault_store    = 1'b1;
                    fault_flag_set = is_low;
                end
                ctf_pkg::FCA_LOCAL_HIGH: begin
                    fault_store    = 1'b1;
                    fault_flag_set = is_high;
                end
                ctf_pkg::FCA_LOCAL_EXTR: begin
                    fault_store    = 1'b1;
                    fault_flag_set = is_low | is_high;
                end
                default: begin
                    fault_store    = 1'b0;
                    fault_flag_set = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            last_store     <= '0;
            prev_fault_cnt <= '0;
            prev_rising    <= 1'b0;
            have_prev      <= 1'b0;
            width_start    <= '0;
            for (int i = 0; i < 4; i++) begin
                store[i] <= '0;
            end
        end else begin
            if (fault_store) begin
                store[ctrl.fault_store_channel_select] <= cnt;
                last_store <= cnt;
            end
            if (fault_rise) begin
                prev_rising    <= cnt >= prev_fault_cnt;
                prev_fault_cnt <= cnt;
                have_prev      <= 1'b1;
            end
            if (ctrl.input1_event_action == ctf_pkg::EV1_PER_WIDTH
                || ctrl.input1_event_action == ctf_pkg::EV1_WIDTH_PER) begin
                if (ev1_rise) begin
                    width_start <= cnt;
                    store[ctrl.input1_event_action == ctf_pkg::EV1_PER_WIDTH ? 0 : 1]
                        <= cnt - width_start;
                end else if (!EVENT_INPUT_ONE_I && ev1_q) begin
                    store[ctrl.input1_event_action == ctf_pkg::EV1_PER_WIDTH ? 1 : 0]
                        <= cnt - width_start;
                end
            end
            if (ctrl.input0_event_action == ctf_pkg::EV0_STAMP && wrap) begin
                store[0] <= cnt;
            end
        end
    end

    // sticky fault flag: a new set wins over a same-cycle clear
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            FAULT_FLAG_O <= 1'b0;
        end else if (fault_flag_set) begin
            FAULT_FLAG_O <= 1'b1;
        end else if (FAULT_FLAG_CLR_I) begin
            FAULT_FLAG_O <= 1'b0;
        end
    end

    logic cyc_ev;
    always_comb begin
        case (ctrl.cycle_output_select)
            ctf_pkg::CYC_BEGIN:    cyc_ev = wrap;
            ctf_pkg::CYC_END:      cyc_ev = do_step & (step_down ? cnt == CNT_W'(1) : cnt == PERIOD_I - 1'b1);
            ctf_pkg::CYC_BETWEEN:  cyc_ev = wrap;
            ctf_pkg::CYC_BOUNDARY: cyc_ev = wrap & first_cycle;
            default:               cyc_ev = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            first_cycle     <= 1'b1;
            COUNTER_EVENT_O <= 1'b0;
            NONREC_FAULT_O  <= 1'b0;
        end else begin
            if (wrap) begin
                first_cycle <= 1'b0;
            end
            COUNTER_EVENT_O <= ovf_en & cyc_ev;
            NONREC_FAULT_O  <= (ev0_rise && ctrl.input0_event_action == ctf_pkg::EV_FAULT)
                            || (ev1_rise && ctrl.input1_event_action == ctf_pkg::EV_FAULT);
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            COUNT_O  <= '0;
            STORE_O  <= '0;
            HALTED_O <= 1'b0;
            STATE_O  <= 2'h0;
        end else begin
            COUNT_O  <= cnt;
            STORE_O  <= {store[3], store[2], store[1], store[0]};
            HALTED_O <= state == ctf_pkg::CTF_HALT;
            STATE_O  <= state;
        end
    end

    a_store_on_fault: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        fault_store |=> store[$past(ctrl.fault_store_channel_select)] == $past(cnt))
        else $error("fault store missed");
    a_flag_sticky: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        fault_flag_set |=> FAULT_FLAG_O)
        else $error("fault flag not set");
    a_disable_no_store: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        fault_action == ctf_pkg::FCA_DISABLE |-> !fault_store)
        else $error("store while capture disabled");
    a_lower_only: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        fault_store && fault_action == ctf_pkg::FCA_IF_LOWER |-> cnt < last_store)
        else $error("store not below last value");
    a_higher_only: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        fault_store && fault_action == ctf_pkg::FCA_IF_HIGHER |-> cnt > last_store)
        else $error("store not above last value");
    a_halt_on_fault: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        state == ctf_pkg::CTF_RUN && halt_now |=> state == ctf_pkg::CTF_HALT)
        else $error("fault did not halt");
    a_event_gated: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        !ovf_en |=> !COUNTER_EVENT_O)
        else $error("counter event while disabled");
    c_fault_store: cover property (@(posedge SYS_CLK_I) fault_store);
    c_wrap: cover property (@(posedge SYS_CLK_I) wrap);
    c_halt: cover property (@(posedge SYS_CLK_I) HALTED_O);
endmodule : ctf_top
`default_nettype wire

// *** bench/ctf_src.sv ***
// event and fault source model driving the timer's event and fault inputs
`timescale 1ns/1ps
`default_nettype none
module ctf_src (
    // clock
    input  wire logic clk_i,
    // event and fault lines
    output logic      ev0_o,
    output logic      ev1_o,
    output logic      fault_o
);
    logic [2:0] lv;

    assign ev0_o   = lv[0];
    assign ev1_o   = lv[1];
    assign fault_o = lv[2];

    initial begin
        lv = 3'h0;
    end

    // levels move just after an edge, so the timer never samples a half-set pulse
    task automatic pulse(input int sel, input int len);
        @(posedge clk_i);
        #1;
        lv[sel] = 1'b1;
        repeat (len) @(posedge clk_i);
        #1;
        lv = 3'h0;
    endtask : pulse
endmodule : ctf_src
`default_nettype wire

// *** bench/tb_ctf_top.sv ***
// self-checking bench for the control timer fault and event logic
`timescale 1ns/1ps
`default_nettype none
module tb_ctf_top;
    logic                          clk;
    logic                          rst;
    ctf_pkg::ctf_ctrl_t            ctrl;
    logic                          ovf_en;
    logic [ctf_pkg::CNT_W-1:0]     period;
    logic                          sw_start;
    logic                          flag_clr;
    logic                          ev0;
    logic                          ev1;
    logic                          fault;
    logic [ctf_pkg::CNT_W-1:0]     count;
    logic [4*ctf_pkg::CNT_W-1:0]   store;
    logic [4*ctf_pkg::CNT_W-1:0]   prev;
    logic [2:0]                    fa;
    logic [ctf_pkg::CNT_W-1:0]     at;
    logic [ctf_pkg::CNT_W-1:0]     last;
    logic [ctf_pkg::CNT_W-1:0]     pv;
    logic                          rising;
    logic                          havep;
    logic                          lo;
    logic                          hi;
    logic                          exp_st;
    logic                          exp_fl;
    logic                          flag;
    logic                          cev;
    logic                          nrf;
    logic                          halted;
    logic [1:0]                    state;
    int                            n;
    int                            n_errors;
    int                            n_checks;

    ctf_top u_dut (
        .SYS_CLK_I(clk), .RESET_I(rst), .CTRL_I(ctrl), .OVF_EVENT_EN_I(ovf_en),
        .PERIOD_I(period), .SW_START_I(sw_start), .FAULT_ACTION_I(fa), .EVENT_INPUT_ZERO_I(ev0),
        .EVENT_INPUT_ONE_I(ev1), .FAULT_I(fault), .FAULT_FLAG_CLR_I(flag_clr),
        .COUNT_O(count), .STORE_O(store), .FAULT_FLAG_O(flag), .COUNTER_EVENT_O(cev),
        .NONREC_FAULT_O(nrf), .HALTED_O(halted), .STATE_O(state)
    );

    ctf_src u_src (.clk_i(clk), .ev0_o(ev0), .ev1_o(ev1), .fault_o(fault));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    // control passes a two-stage sync, so give it three edges
    task automatic set_ctrl(input ctf_pkg::ctf_ctrl_t c);
        ctrl = c;
        tick(3);
    endtask : set_ctrl

    // one fault pulse; at is the count the timer holds at the fault edge
    task automatic fault_shot();
        fork
            u_src.pulse(2, 1);
            begin
                tick(2);
                at = count;
            end
        join
        hi     = havep && rising && at < pv;
        lo     = havep && !rising && at > pv;
        rising = at >= pv;
        pv     = at;
        havep  = 1'b1;
        tick(2);
    endtask : fault_shot

    task automatic count_pulse(input int sel, input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc) begin
            tick(1);
            if ((sel == 0 ? cev : nrf) === 1'b1) cnt++;
        end
    endtask : count_pulse

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        ctrl = '0;
        ovf_en = 1'b0;
        period = 16'h0010;
        fa = ctf_pkg::FCA_STORE;
        last = '0;
        pv = '0;
        rising = 1'b0;
        havep = 1'b0;
        sw_start = 1'b0;
        flag_clr = 1'b0;
        n_errors = 0;
        n_checks = 0;
        tick(10);
        rst = 1'b0;
        tick(1);
        check_val({count, flag, cev, nrf, halted, state}, 64'h0);
        check_val(store, 64'h0);
        sw_start = 1'b1;
        // fault store routed to each channel
        for (int ch = 0; ch < 4; ch++) begin
            ctrl = '0;
            ctrl.fault_store_channel_select = ch[1:0];
            set_ctrl(ctrl);
            prev = store;
            fault_shot();
            last = at;
            check_val(store[16*ch +: 16], at);
            check_val((store ^ prev) & ~(64'hffff << (16 * ch)), 64'h0);
            check_bit(flag, 1'b1);
            flag_clr = 1'b1;
            tick(2);
            flag_clr = 1'b0;
            tick(1);
            check_bit(flag, 1'b0);
        end
        // every capture action on channel 0, judged against the last stored value or, for the local extremes, the trend of fault counts
        for (int a = 0; a < 7; a++) begin
            fa = a[2:0];
            set_ctrl('0);
            for (int k = 0; k < 3; k++) begin
                prev = store;
                fault_shot();
                case (a)
                    0:       exp_st = 1'b0;
                    2:       exp_st = at < last;
                    3:       exp_st = at > last;
                    default: exp_st = 1'b1;
                endcase
                case (a)
                    0:       exp_fl = 1'b0;
                    1, 2, 3: exp_fl = exp_st;
                    4:       exp_fl = lo;
                    5:       exp_fl = hi;
                    default: exp_fl = lo | hi;
                endcase
                if (exp_st) last = at;
                check_val(store[15:0], exp_st ? at : prev[15:0]);
                check_bit(flag, exp_fl);
                flag_clr = 1'b1;
                tick(1);
                flag_clr = 1'b0;
            end
        end
        // unrecoverable fault action on each input, and the off action
        for (int i = 0; i < 2; i++) begin
            for (int j = 0; j < 2; j++) begin
                ctrl = '0;
                if (i == 0) ctrl.input0_event_action = j ? ctf_pkg::EV_OFF : ctf_pkg::EV_FAULT;
                else ctrl.input1_event_action = j ? ctf_pkg::EV_OFF : ctf_pkg::EV_FAULT;
                set_ctrl(ctrl);
                fork
                    u_src.pulse(i, 1);
                    count_pulse(1, 8, n);
                join
                check_bit(n > 0, j == 0);
            end
        end
        // counter event per cycle placement, gated by the wrap enable
        for (int cyc = 0; cyc < 4; cyc++) begin
            ctrl = '0;
            ctrl.cycle_output_select = cyc[1:0];
            ovf_en = 1'b1;
            set_ctrl(ctrl);
            count_pulse(0, 40, n);
            check_bit(n > 0, cyc != 3);
            ovf_en = 1'b0;
            tick(3);
            count_pulse(0, 40, n);
            check_val(n, 64'h0);
        end
        // software halt on a fault holds the count until a software start
        period = 16'h00ff;
        sw_start = 1'b0;
        ctrl = '0;
        ctrl.halt_action = ctf_pkg::HALT_SW;
        set_ctrl(ctrl);
        fault_shot();
        check_bit(halted, 1'b1);
        prev = {48'h0, count};
        tick(3);
        check_val({48'h0, count}, prev);
        sw_start = 1'b1;
        tick(2);
        check_bit(halted, 1'b0);
        // count only while input zero stands high
        ctrl = '0;
        ctrl.input0_event_action = ctf_pkg::EV0_COUNT_LEVEL;
        set_ctrl(ctrl);
        prev = {48'h0, count};
        tick(3);
        check_val({48'h0, count}, prev);
        u_src.pulse(0, 4);
        tick(2);
        check_val({48'h0, count}, prev + 64'h4);
        // rising edges four cycles apart, each three cycles wide
        ctrl.input0_event_action = ctf_pkg::EV_OFF;
        ctrl.input1_event_action = ctf_pkg::EV1_PER_WIDTH;
        set_ctrl(ctrl);
        u_src.pulse(1, 3);
        u_src.pulse(1, 3);
        tick(3);
        check_val(store[31:0], {16'h0003, 16'h0004});
        // the wrap stamps the top count into channel 0
        ctrl.input1_event_action = ctf_pkg::EV_OFF;
        ctrl.input0_event_action = ctf_pkg::EV0_STAMP;
        set_ctrl(ctrl);
        tick(270);
        check_val(store[15:0], period);
        // stop on input one, then start again from input zero
        ctrl = '0;
        ctrl.input1_event_action = ctf_pkg::EV1_STOP;
        ctrl.input0_event_action = ctf_pkg::EV0_START;
        set_ctrl(ctrl);
        sw_start = 1'b0;
        u_src.pulse(1, 1);
        tick(4);
        prev = {48'h0, count};
        tick(6);
        check_val({48'h0, count}, prev);
        u_src.pulse(0, 1);
        tick(4);
        check_bit(count !== prev[15:0], 1'b1);
        print_verdict();
    end
endmodule : tb_ctf_top
`default_nettype wire
